/* File: hdl/plgpm_defines.vh */
// Purpose: Register map and field layout of the shared lamp / GPIO pad controller
// Assumes: AXI4-Lite, 32-bit data, word-aligned registers
// Notes:   Definitions only
`ifndef PLGPM_DEFINES_VH
`define PLGPM_DEFINES_VH
`define PLGPM_ADDR_W        8
`define PLGPM_LAMP_CFG_OFS  8'h00
`define PLGPM_GPIO_CFG_OFS  8'h04
`define PLGPM_GPIO_DDR_OFS  8'h08
`define PLGPM_MDIX_OFS      8'h0c
`define PLGPM_PAD_STAT_OFS  8'h10
`define PLGPM_LAMP_EN_LSB   0
`define PLGPM_LAMP_SEL_LSB  8
`define PLGPM_LAMP_SEL_MSB  9
`define PLGPM_GPIO_OD_LSB   0
`define PLGPM_GPIO_DATA_LSB 0
`define PLGPM_GPIO_DIR_LSB  8
`define PLGPM_MDIX_AUTO_LSB 0
`define PLGPM_MDIX_FRC_LSB  8
`define PLGPM_LAMP_CFG_RST  32'h0000_0000
`define PLGPM_GPIO_CFG_RST  32'h0000_0000
`define PLGPM_GPIO_DDR_RST  32'h0000_0000
`define PLGPM_MDIX_RST      32'h0000_0000
`define PLGPM_RESP_OKAY     2'h0
`define PLGPM_RESP_SLVERR   2'h2
`endif

/* File: hdl/plgpm_pad_cell.v */
// Purpose: Control of one shared lamp / GPIO pad
// Assumes: All inputs synchronous to clock
// Notes:   Outputs are registered so the top drives pads straight from flops
`timescale 1ns/1ns
module plgpm_pad_cell (
   input  wire clock,
   input  wire rst_n,
   input  wire lamp_mode,
   input  wire lamp_on,
   input  wire gpio_od,
   input  wire gpio_out,
   input  wire gpio_data,
   output reg  pad_out_ff,
   output reg  pad_oe_ff,
   output reg  pad_pu_en_ff,
   output reg  pad_ie_ff
);
   reg nxt_pad_oe;
   reg nxt_pad_out;

   always @* begin
      nxt_pad_out = 1'b0;
      nxt_pad_oe  = 1'b0;
      if (lamp_mode) begin
         nxt_pad_oe = lamp_on;
      end else if (gpio_out) begin
         if (gpio_od) begin
            nxt_pad_oe = ~gpio_data;
         end else begin
            nxt_pad_out = gpio_data;
            nxt_pad_oe  = 1'b1;
         end
      end
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         pad_out_ff   <= 1'b0;
         pad_oe_ff    <= 1'b0;
         pad_pu_en_ff <= 1'b1;
         pad_ie_ff    <= 1'b1;
      end else begin
         pad_out_ff   <= nxt_pad_out;
         pad_oe_ff    <= nxt_pad_oe;
         pad_pu_en_ff <= ~lamp_mode;
         pad_ie_ff    <= ~lamp_mode & ~gpio_out;
      end
   end
endmodule

/* File: hdl/plgpm_pin_mux.v */
// Purpose: Shared port-lamp / GPIO pin mux and twisted-pair swap for two ports
// Assumes: One 20 MHz clock, synchronous active-low reset, AXI4-Lite slave
// Notes:   Lamp status sources come from the port PHYs as levels
//          Pads follow a register write one cycle after its response
`timescale 1ns/1ns
`include "plgpm_defines.vh"

module plgpm_pin_mux #(
   parameter NPIN = 8
) (
   input  wire                     clock,
   input  wire                     rst_n,
   input  wire [`PLGPM_ADDR_W-1:0] s_axi_awaddr,
   input  wire                     s_axi_awvalid,
   output reg                      s_axi_awready,
   input  wire [31:0]              s_axi_wdata,
   input  wire [3:0]               s_axi_wstrb,
   input  wire                     s_axi_wvalid,
   output reg                      s_axi_wready,
   output reg  [1:0]               s_axi_bresp,
   output reg                      s_axi_bvalid,
   input  wire                     s_axi_bready,
   input  wire [`PLGPM_ADDR_W-1:0] s_axi_araddr,
   input  wire                     s_axi_arvalid,
   output reg                      s_axi_arready,
   output reg  [31:0]              s_axi_rdata,
   output reg  [1:0]               s_axi_rresp,
   output reg                      s_axi_rvalid,
   input  wire                     s_axi_rready,
   input  wire [15:0]              port1_status,
   input  wire [15:0]              port2_status,
   input  wire [1:0]               port_reversed,
   input  wire [NPIN-1:0]          pad_in,
   output wire [NPIN-1:0]          pad_out,
   output wire [NPIN-1:0]          pad_oe,
   output wire [NPIN-1:0]          pad_pu_en,
   output wire [NPIN-1:0]          pad_ie,
   output reg  [1:0]               pair_swap_ff
);
   reg  [31:0]              lamp_cfg_ff;
   reg  [31:0]              gpio_cfg_ff;
   reg  [31:0]              gpio_ddr_ff;
   reg  [31:0]              mdix_ff;
   reg  [NPIN-1:0]          pad_in_ff;
   reg  [`PLGPM_ADDR_W-1:0] awaddr_ff;
   reg  [31:0]              wdata_ff;
   reg  [3:0]               wstrb_ff;
   reg                      aw_held_ff;
   reg                      w_held_ff;
   reg  [31:0]              nxt_rdata;
   reg  [1:0]               nxt_rresp;
   reg  [NPIN-1:0]          lamp_on;
   wire [1:0]               lamp_sel;
   wire                     wr_go;
   wire                     wr_hit;
   wire [31:0]              pad_stat;
   integer                  i;
   integer                  j;
   integer                  k;

   assign lamp_sel = lamp_cfg_ff[`PLGPM_LAMP_SEL_MSB:`PLGPM_LAMP_SEL_LSB];
   assign wr_go    = aw_held_ff & w_held_ff & ~s_axi_bvalid;
   // An unmapped write is answered with an error and changes nothing
   assign wr_hit   = (awaddr_ff == `PLGPM_LAMP_CFG_OFS) | (awaddr_ff == `PLGPM_GPIO_CFG_OFS) |
                     (awaddr_ff == `PLGPM_GPIO_DDR_OFS) | (awaddr_ff == `PLGPM_MDIX_OFS);
   // Input receiver off reads as zero, as the pad does
   assign pad_stat = {{(30-NPIN){1'b0}}, pair_swap_ff, pad_in_ff & pad_ie};

   // Each status input carries four candidate sources per lamp, picked by the select field
   always @* begin
      for (i = 0; i < NPIN; i = i + 1) begin
         if (i < 4) begin
            lamp_on[i] = port1_status[lamp_sel*4 + i];
         end else begin
            lamp_on[i] = port2_status[lamp_sel*4 + i - 4];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : g_pad
         plgpm_pad_cell u_pad (
            .clock        (clock),
            .rst_n        (rst_n),
            .lamp_mode    (lamp_cfg_ff[`PLGPM_LAMP_EN_LSB + g]),
            .lamp_on      (lamp_on[g]),
            .gpio_od      (gpio_cfg_ff[`PLGPM_GPIO_OD_LSB + g]),
            .gpio_out     (gpio_ddr_ff[`PLGPM_GPIO_DIR_LSB + g]),
            .gpio_data    (gpio_ddr_ff[`PLGPM_GPIO_DATA_LSB + g]),
            .pad_out_ff   (pad_out[g]),
            .pad_oe_ff    (pad_oe[g]),
            .pad_pu_en_ff (pad_pu_en[g]),
            .pad_ie_ff    (pad_ie[g])
         );
      end
   endgenerate

   // Write channel: address and data accepted in either order, answer after both
   always @(posedge clock) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         awaddr_ff     <= {`PLGPM_ADDR_W{1'b0}};
         wdata_ff      <= 32'h0000_0000;
         wstrb_ff      <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PLGPM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awaddr_ff     <= s_axi_awaddr;
            aw_held_ff    <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wdata_ff     <= s_axi_wdata;
            wstrb_ff     <= s_axi_wstrb;
            w_held_ff    <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `PLGPM_RESP_OKAY;
            if (!wr_hit) begin
               s_axi_bresp <= `PLGPM_RESP_SLVERR;
            end
         end
         // Readies stay low until the response is taken, so one write is in flight
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Register file, written in the cycle that raises the write response
   // Byte strobes let software change one field without a read-modify-write
   always @(posedge clock) begin
      if (!rst_n) begin
         lamp_cfg_ff <= `PLGPM_LAMP_CFG_RST;
         gpio_cfg_ff <= `PLGPM_GPIO_CFG_RST;
         gpio_ddr_ff <= `PLGPM_GPIO_DDR_RST;
         mdix_ff     <= `PLGPM_MDIX_RST;
      end else if (wr_go) begin
         for (j = 0; j < 4; j = j + 1) begin
            if (wstrb_ff[j]) begin
               case (awaddr_ff)
                  `PLGPM_LAMP_CFG_OFS: lamp_cfg_ff[j*8 +: 8] <= wdata_ff[j*8 +: 8];
                  `PLGPM_GPIO_CFG_OFS: gpio_cfg_ff[j*8 +: 8] <= wdata_ff[j*8 +: 8];
                  `PLGPM_GPIO_DDR_OFS: gpio_ddr_ff[j*8 +: 8] <= wdata_ff[j*8 +: 8];
                  `PLGPM_MDIX_OFS:     mdix_ff[j*8 +: 8]     <= wdata_ff[j*8 +: 8];
                  default: ;
               endcase
            end
         end
      end
   end

   always @* begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = `PLGPM_RESP_OKAY;
      case (s_axi_araddr)
         `PLGPM_LAMP_CFG_OFS: nxt_rdata = lamp_cfg_ff;
         `PLGPM_GPIO_CFG_OFS: nxt_rdata = gpio_cfg_ff;
         `PLGPM_GPIO_DDR_OFS: nxt_rdata = gpio_ddr_ff;
         `PLGPM_MDIX_OFS:     nxt_rdata = mdix_ff;
         `PLGPM_PAD_STAT_OFS: nxt_rdata = pad_stat;
         default:             nxt_rresp = `PLGPM_RESP_SLVERR;
      endcase
   end

   // Bits 0/1 enable auto crossover per port, bits 8/9 force the reverse
   always @(posedge clock) begin
      if (!rst_n) begin
         pair_swap_ff <= 2'h0;
      end else begin
         for (k = 0; k < 2; k = k + 1) begin
            pair_swap_ff[k] <= (mdix_ff[`PLGPM_MDIX_AUTO_LSB + k] & port_reversed[k]) |
                               mdix_ff[`PLGPM_MDIX_FRC_LSB + k];
         end
      end
   end

   // Read channel: one read in flight, answered on the edge after the address
   always @(posedge clock) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `PLGPM_RESP_OKAY;
         pad_in_ff     <= {NPIN{1'b0}};
      end else begin
         // Pads are sampled once so a status read never sees a half-settled level
         pad_in_ff <= pad_in;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= nxt_rdata;
            s_axi_rresp   <= nxt_rresp;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

/* File: bench/plgpm_pin_mux_props.sv */
// Purpose: Port properties of the shared pad mux
// Assumes: Lamp mode shows as pull-up off
// Notes:   Bound to the top below
`timescale 1ns/1ns
module plgpm_pin_mux_props #(
   parameter NPIN = 8
) (
   input wire            clock,
   input wire            rst_n,
   input wire            s_axi_awvalid,
   input wire            s_axi_awready,
   input wire            s_axi_wvalid,
   input wire            s_axi_wready,
   input wire            s_axi_bvalid,
   input wire            s_axi_bready,
   input wire            s_axi_arvalid,
   input wire            s_axi_arready,
   input wire            s_axi_rvalid,
   input wire            s_axi_rready,
   input wire [NPIN-1:0] pad_out,
   input wire [NPIN-1:0] pad_oe,
   input wire [NPIN-1:0] pad_pu_en,
   input wire [NPIN-1:0] pad_ie,
   input wire [1:0]      pair_swap_ff
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence b_done;
      s_axi_bvalid && s_axi_bready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence r_done;
      s_axi_rvalid && s_axi_rready;
   endsequence
   chk_lamp_no_rx: assert property ((~pad_pu_en & pad_ie) == '0) else $error("lamp rx");
   chk_lamp_low_only: assert property ((~pad_pu_en & pad_out) == '0) else $error("lamp hi");
   chk_out_rx_off: assert property ((pad_oe & pad_ie) == '0) else $error("out rx");
   chk_reset_pads: assert property ($rose(rst_n) |->
      pad_oe == '0 && &pad_pu_en && &pad_ie && pair_swap_ff == 2'h0) else $error("reset pads");
   chk_pull_cfg: assert property ($changed(pad_pu_en) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("pull moved");
   chk_write_answer: assert property (both_taken |-> ##2 s_axi_bvalid) else $error("no bresp");
   chk_b_once: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("b stuck");
   chk_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
   chk_read_answer: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("no rvalid");
   chk_r_once: assert property (r_done |=> !s_axi_rvalid && s_axi_arready) else $error("r stuck");
endmodule
bind plgpm_pin_mux plgpm_pin_mux_props #(.NPIN(NPIN)) i_plgpm_pin_mux_props (.clock, .rst_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pad_out, .pad_oe,
   .pad_pu_en, .pad_ie, .pair_swap_ff);

/* File: bench/plgpm_board_model.sv */
// Purpose: Board side of the shared pads
// Assumes: Lamps hang from the supply
// Notes:   An undriven pad reads high
`timescale 1ns/1ns
module plgpm_board_model (
   input  wire [7:0] pad_out,
   input  wire [7:0] pad_oe,
   input  wire [7:0] pad_pu_en,
   input  wire [7:0] brd_val,
   input  wire [7:0] brd_en,
   output wire [7:0] pad_in,
   output wire [7:0] lamp_lit
);
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & (~brd_en | brd_val));
   assign lamp_lit = pad_oe & ~pad_out & ~pad_pu_en;
endmodule

/* File: bench/port_led_gpio_pin_mux_tb_top.sv */
// Purpose: Bench for the shared pad mux
// Assumes: One bus access at a time
// Notes:   Responses checked from a queue
`timescale 1ns/1ns
module port_led_gpio_pin_mux_tb_top;
   logic        clock = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, brd_val = 0, brd_en = 0;
   logic [7:0]  pad_in, pad_out, pad_oe, pad_pu_en, pad_ie, lamp_lit;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [15:0] port1_status = 0, port2_status = 0;
   logic [1:0]  port_reversed = 0, s_axi_bresp, s_axi_rresp, pair_swap_ff;
   logic [33:0] expq[$];
   int          mismatches = 0, tests_run = 0;
   always #25 clock = ~clock;
   plgpm_pin_mux i_plgpm_pin_mux (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .port1_status, .port2_status, .port_reversed, .pad_in,
      .pad_out, .pad_oe, .pad_pu_en, .pad_ie, .pair_swap_ff);
   plgpm_board_model i_plgpm_board_model (.pad_out, .pad_oe, .pad_pu_en, .brd_val, .brd_en,
      .pad_in, .lamp_lit);
   task chk(input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Pads lag the register by a cycle, so each write waits two edges after its response
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      expq.push_back({r, 32'h0});
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      repeat (2) @(posedge clock);
   endtask
   task rd(input logic [7:0] a, input logic [33:0] e);
      expq.push_back(e);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask
   always @(posedge clock) begin
      if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, expq.pop_front());
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
   end
   task close_out;
      if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      close_out;
   end
   initial begin
      void'($urandom(32'h02ef0c36));
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      d = $urandom;
      @(posedge clock);
      chk({pad_oe, pad_pu_en, pad_ie}, 24'h00ffff);
      wr(8'h08, {16'h0, 8'hff, d[7:0]}, 2'h0);
      chk({pad_oe, pad_out, pad_ie, pad_pu_en}, {8'hff, d[7:0], 16'h00ff});
      wr(8'h04, 32'hff, 2'h0);
      chk({pad_oe, pad_out}, {~d[7:0], 8'h0});
      brd_en <= 8'hff;
      brd_val <= d[15:8];
      wr(8'h08, 32'h0, 2'h0);
      rd(8'h10, {26'h0, d[15:8]});
      for (int s = 0; s < 4; s++) begin
         d = $urandom;
         port1_status <= d[15:0];
         port2_status <= d[31:16];
         wr(8'h00, {22'h0, s[1:0], 8'hff}, 2'h0);
         chk(lamp_lit, {port2_status[s*4+:4], port1_status[s*4+:4]});
         chk({pad_pu_en, pad_ie, pad_out}, 24'h0);
      end
      port_reversed <= 2'h1;
      wr(8'h0c, 32'h3, 2'h0);
      chk(pair_swap_ff, 2'h1);
      wr(8'h0c, 32'h200, 2'h0);
      rd(8'h10, {24'h0, 2'h2, 8'h0});
      s_axi_wstrb <= 4'h1;
      wr(8'h0c, 32'h0000_0301, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd(8'h0c, {2'h0, 32'h0000_0201});
      chk(pair_swap_ff, 2'h3);
      wr(8'h20, 32'hffff_ffff, 2'h2);
      rd(8'h20, {2'h2, 32'h0});
      close_out;
   end
endmodule
